// [hdl/rsps_defs.svh]
/*
 Offsets, field positions, reset values and timing counts of the ramp-and-soak
 program sequencer. Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
`ifndef RSPS_DEFS_SVH
`define RSPS_DEFS_SVH

// Register byte offsets
`define RSPS_OFS_CTRL 8'h00
`define RSPS_OFS_TOL 8'h04
`define RSPS_OFS_STAT 8'h0C
`define RSPS_OFS_TLEFT 8'h10
`define RSPS_OFS_WSP 8'h14
`define RSPS_OFS_IST 8'h18
`define RSPS_OFS_IMSK 8'h1C
`define RSPS_OFS_EVFN 8'h20
// Program window: byte 8'h80 + 4 * field, for the program chosen for editing
`define RSPS_WIN_BIT 7
`define RSPS_FLD_SP0 5'h00
`define RSPS_FLD_DUR0 5'h09
`define RSPS_FLD_EV0 5'h12
`define RSPS_FLD_LINK 5'h1C

// Control register fields
`define RSPS_CTRL_SEL_LSB 0
`define RSPS_CTRL_TB_BIT 5
`define RSPS_CTRL_CEN_BIT 6
`define RSPS_CTRL_EDIT_LSB 8

// Limits and reset values
`define RSPS_NUM_PROG 5'h14
`define RSPS_LAST_SEG 4'h9
`define RSPS_EDIT_RST 5'h01
`define RSPS_CEN_RST 1'h1

// Interrupt bits
`define RSPS_IRQ_SEG 0
`define RSPS_IRQ_END 1
`define RSPS_IRQ_HOLD 2

// Timing
`define RSPS_CLK_NS 32'h0000_000A
`define RSPS_SEC_NS 32'h3B9A_CA00
`define RSPS_MIN_SEC 6'h3C

`endif

// [hdl/rsps_pkg.sv]
/*
 Types of the ramp-and-soak program sequencer.
 Assumes nothing of its surroundings.
*/
package rsps_pkg;
   typedef enum logic [1:0] {
      RSPS_IDLE,
      RSPS_LOAD,
      RSPS_RUN
   } rsps_state_t;
endpackage

// [hdl/rsps_seq.sv]
/*
 Ramp-and-soak program sequencer: 20 stored programs, segment timer on a
 seconds or minutes base, tolerance hold, event alarms, program linking and a
 Wishbone register slave with interrupt. Assumes a 100 MHz clock, PV sampled
 synchronously and a classic single-cycle Wishbone master.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rsps_defs.svh"

module rsps_seq #(
   parameter logic [31:0] P_SEC_CYC = `RSPS_SEC_NS / `RSPS_CLK_NS
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic [15:0] i_pv,
   output logic [15:0] o_setpoint,
   output logic [3:0] o_event_alarm,
   output logic o_ctrl_active,
   output logic o_irq
);
   logic [4:0] run_sel_ff, edit_ff, prog_ff;
   logic tb_min_ff, cen_ff, sel_chg_ff, held_d_ff;
   logic [15:0] tol_ff, tleft_ff, wsp_ff;
   logic [3:0] evfn_ff, seg_ff, evo_ff;
   logic [2:0] ist_ff, imsk_ff;
   logic [31:0] sec_cnt_ff;
   logic [5:0] min_cnt_ff;
   logic [15:0] mem_ff [0:639];
   rsps_pkg::rsps_state_t state_ff;

   function automatic logic [9:0] midx(input logic [4:0] p, input logic [4:0] f);
      midx = {5'(p - 5'h01), f};
   endfunction

   function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
   endfunction

   function automatic logic [15:0] ramp(input logic [15:0] a, input logic [15:0] b,
                                        input logic [15:0] d, input logic [15:0] t);
      logic signed [16:0] df;
      logic signed [33:0] pr;
      logic signed [33:0] q;
      df = $signed({b[15], b}) - $signed({a[15], a});
      pr = 34'(df * $signed({1'b0, 16'(d - t)}));
      q = (d == 16'h0000) ? '0 : pr / $signed({18'h0_0000, d});
      ramp = a + q[15:0];
   endfunction

   // Bus decode; a request is taken on its first cycle and acked on the next
   logic wb_hit, wb_wr, win;
   logic [4:0] fld;
   logic [31:0] cur_ctrl, wd_ctrl, wd_tol;
   assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wb_wr = wb_hit && i_wb_we;
   assign win = i_wb_adr[`RSPS_WIN_BIT];
   assign fld = i_wb_adr[6:2];
   assign cur_ctrl = {19'h0_0000, edit_ff, 1'b0, cen_ff, tb_min_ff, run_sel_ff};
   assign wd_ctrl = wmask(cur_ctrl, i_wb_dat, i_wb_sel);
   assign wd_tol = wmask({16'h0000, tol_ff}, i_wb_dat, i_wb_sel);

   // Values read by the sequencer from the running program
   logic running, held, tb_tick, sec_tick, ctr_clr, seg_end, link_ok;
   logic [15:0] dur_cur, dur_nxt, dur_load, sp_a, sp_b, link_v;
   logic [3:0] ev_cur;
   logic [16:0] dev;
   assign running = (state_ff == rsps_pkg::RSPS_RUN);
   assign dur_cur = mem_ff[midx(prog_ff, 5'({1'b0, seg_ff} + `RSPS_FLD_DUR0))];
   assign dur_nxt = mem_ff[midx(prog_ff, 5'({1'b0, seg_ff} + 5'h0A))];
   assign dur_load = mem_ff[midx(prog_ff, 5'h0A)];
   assign sp_a = mem_ff[midx(prog_ff, 5'({1'b0, seg_ff} - 5'h01))];
   assign sp_b = mem_ff[midx(prog_ff, {1'b0, seg_ff})];
   assign ev_cur = mem_ff[midx(prog_ff, 5'({1'b0, seg_ff} + `RSPS_FLD_EV0))][3:0];
   assign link_v = mem_ff[midx(prog_ff, `RSPS_FLD_LINK)];
   assign link_ok = (link_v != 16'h0000) && (link_v <= {11'h000, `RSPS_NUM_PROG});
   assign seg_end = running && (tleft_ff == 16'h0000);
   assign dev = ($signed(i_pv) >= $signed(wsp_ff)) ?
                17'({i_pv[15], i_pv} - {wsp_ff[15], wsp_ff}) :
                17'({wsp_ff[15], wsp_ff} - {i_pv[15], i_pv});
   assign held = running && (tol_ff != 16'h0000) && (dev > {1'b0, tol_ff});

   // Control, tolerance, event function, mask and selection registers
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         run_sel_ff <= 5'h00;
         tb_min_ff <= 1'b0;
         cen_ff <= `RSPS_CEN_RST;
         edit_ff <= `RSPS_EDIT_RST;
         sel_chg_ff <= 1'b0;
         tol_ff <= 16'h0000;
         evfn_ff <= 4'h0;
         imsk_ff <= 3'h0;
      end else begin
         sel_chg_ff <= 1'b0;
         if (wb_wr && !win) begin
            case (i_wb_adr)
               `RSPS_OFS_CTRL: begin
                  run_sel_ff <= wd_ctrl[4:0];
                  sel_chg_ff <= (wd_ctrl[4:0] != run_sel_ff);
                  tb_min_ff <= wd_ctrl[`RSPS_CTRL_TB_BIT];
                  cen_ff <= wd_ctrl[`RSPS_CTRL_CEN_BIT];
                  edit_ff <= wd_ctrl[`RSPS_CTRL_EDIT_LSB +: 5];
               end
               `RSPS_OFS_TOL: tol_ff <= wd_tol[15:0];
               `RSPS_OFS_EVFN: if (i_wb_sel[0]) evfn_ff <= i_wb_dat[3:0];
               `RSPS_OFS_IMSK: if (i_wb_sel[0]) imsk_ff <= i_wb_dat[2:0];
               default: ;
            endcase
         end
      end
   end

   // Program store: setpoints, durations, events and link of 20 programs
   always_ff @(posedge i_clk) begin
      if (wb_wr && win && edit_ff != 5'h00 && edit_ff <= `RSPS_NUM_PROG
          && fld <= `RSPS_FLD_LINK && (i_wb_sel[1:0] == 2'h3)) begin
         mem_ff[midx(edit_ff, fld)] <= i_wb_dat[15:0];
      end
   end

   // Time base divider, restarted with each program load
   assign ctr_clr = (state_ff == rsps_pkg::RSPS_LOAD);
   assign sec_tick = (sec_cnt_ff == P_SEC_CYC - 32'h0000_0001);
   assign tb_tick = sec_tick && (!tb_min_ff || min_cnt_ff == `RSPS_MIN_SEC - 6'h01);
   always_ff @(posedge i_clk) begin
      if (!i_nrst || ctr_clr) begin
         sec_cnt_ff <= 32'h0000_0000;
         min_cnt_ff <= 6'h00;
      end else if (sec_tick) begin
         sec_cnt_ff <= 32'h0000_0000;
         min_cnt_ff <= (min_cnt_ff == `RSPS_MIN_SEC - 6'h01) ? 6'h00 : 6'(min_cnt_ff + 6'h01);
      end else begin
         sec_cnt_ff <= 32'(sec_cnt_ff + 32'h0000_0001);
      end
   end

   // Sequencer
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_ff <= rsps_pkg::RSPS_IDLE;
         prog_ff <= 5'h01;
         seg_ff <= 4'h0;
         tleft_ff <= 16'h0000;
      end else if (run_sel_ff == 5'h00 || run_sel_ff > `RSPS_NUM_PROG) begin
         state_ff <= rsps_pkg::RSPS_IDLE;
         seg_ff <= 4'h0;
         tleft_ff <= 16'h0000;
      end else if (sel_chg_ff) begin
         state_ff <= rsps_pkg::RSPS_LOAD;
         prog_ff <= run_sel_ff;
      end else begin
         case (state_ff)
            rsps_pkg::RSPS_IDLE: begin
               seg_ff <= 4'h0;
               tleft_ff <= 16'h0000;
            end
            rsps_pkg::RSPS_LOAD: begin
               seg_ff <= 4'h1;
               tleft_ff <= dur_load;
               state_ff <= rsps_pkg::RSPS_RUN;
            end
            rsps_pkg::RSPS_RUN: begin
               if (seg_end && seg_ff == `RSPS_LAST_SEG) begin
                  if (link_ok) begin
                     prog_ff <= link_v[4:0];
                     state_ff <= rsps_pkg::RSPS_LOAD;
                  end else begin
                     state_ff <= rsps_pkg::RSPS_IDLE;
                  end
               end else if (seg_end) begin
                  seg_ff <= 4'(seg_ff + 4'h1);
                  tleft_ff <= dur_nxt;
               end else if (tb_tick && cen_ff && !held) begin
                  tleft_ff <= 16'(tleft_ff - 16'h0001);
               end
            end
            default: state_ff <= rsps_pkg::RSPS_IDLE;
         endcase
      end
   end

   // Working setpoint and event alarm outputs
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wsp_ff <= 16'h0000;
         evo_ff <= 4'h0;
      end else begin
         if (running && seg_ff != 4'h0) begin
            wsp_ff <= ramp(sp_a, sp_b, dur_cur, tleft_ff);
         end
         evo_ff <= (running && cen_ff) ? (ev_cur & evfn_ff) : 4'h0;
      end
   end
   assign o_setpoint = wsp_ff;
   assign o_event_alarm = evo_ff;
   assign o_ctrl_active = cen_ff;

   // Interrupt status: set wins over write-one-to-clear
   logic [2:0] ist_set, ist_clr;
   assign ist_set = {held && !held_d_ff, seg_end && seg_ff == `RSPS_LAST_SEG,
                     seg_end && seg_ff != `RSPS_LAST_SEG};
   assign ist_clr = (wb_wr && !win && i_wb_adr == `RSPS_OFS_IST && i_wb_sel[0]) ?
                    i_wb_dat[2:0] : 3'h0;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ist_ff <= 3'h0;
         held_d_ff <= 1'b0;
      end else begin
         ist_ff <= (ist_ff & ~ist_clr) | ist_set;
         held_d_ff <= held;
      end
   end
   assign o_irq = |(ist_ff & imsk_ff);

   // Read data and ack
   logic [31:0] rd;
   always_comb begin
      rd = 32'h0000_0000;
      if (win) begin
         if (edit_ff != 5'h00 && edit_ff <= `RSPS_NUM_PROG && fld <= `RSPS_FLD_LINK) begin
            rd = {16'h0000, mem_ff[midx(edit_ff, fld)]};
         end
      end else begin
         case (i_wb_adr)
            `RSPS_OFS_CTRL: rd = cur_ctrl;
            `RSPS_OFS_TOL: rd = {16'h0000, tol_ff};
            `RSPS_OFS_STAT: rd = {21'h00_0000, held, running, prog_ff, seg_ff};
            `RSPS_OFS_TLEFT: rd = {16'h0000, tleft_ff};
            `RSPS_OFS_WSP: rd = {16'h0000, wsp_ff};
            `RSPS_OFS_IST: rd = {29'h0000_0000, ist_ff};
            `RSPS_OFS_IMSK: rd = {29'h0000_0000, imsk_ff};
            `RSPS_OFS_EVFN: rd = {28'h000_0000, evfn_ff};
            default: rd = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= wb_hit;
         if (wb_hit) o_wb_dat <= rd;
      end
   end

   // Checks
   logic ok_ctx;
   assign ok_ctx = run_sel_ff != 5'h00 && run_sel_ff <= `RSPS_NUM_PROG && !sel_chg_ff;
   chk_idle_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
      run_sel_ff == 5'h00 |=> state_ff == rsps_pkg::RSPS_IDLE)
      else $error("Sequencer active with no program selected");
   chk_seg_range: assert property (@(posedge i_clk) disable iff (!i_nrst)
      running |-> seg_ff >= 4'h1 && seg_ff <= `RSPS_LAST_SEG)
      else $error("Active segment out of range");
   chk_tleft_dec: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ok_ctx && running && !seg_end && tb_tick && cen_ff && !held
      |=> tleft_ff == 16'($past(tleft_ff) - 16'h0001))
      else $error("Time left did not count down on tick");
   chk_cen_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !cen_ff ##1 !cen_ff |-> o_event_alarm == 4'h0 && !o_ctrl_active)
      else $error("Alarms active while control disabled");
   chk_tb_minute: assert property (@(posedge i_clk) disable iff (!i_nrst)
      tb_min_ff && tb_tick |-> min_cnt_ff == `RSPS_MIN_SEC - 6'h01)
      else $error("Minute base ticked early");
   chk_hold_freeze: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ok_ctx && running && held && !seg_end |=> $stable(tleft_ff))
      else $error("Timer moved while PV outside tolerance");
   chk_event_map: assert property (@(posedge i_clk) disable iff (!i_nrst)
      running && cen_ff |=> o_event_alarm == ($past(ev_cur) & $past(evfn_ff)))
      else $error("Event alarms do not follow segment setting");
   chk_link_stop: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ok_ctx && seg_end && seg_ff == `RSPS_LAST_SEG && !link_ok
      |=> state_ff == rsps_pkg::RSPS_IDLE ##1 state_ff == rsps_pkg::RSPS_IDLE)
      else $error("Execution did not stop without link");
   chk_link_go: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ok_ctx && seg_end && seg_ff == `RSPS_LAST_SEG && link_ok
      |=> prog_ff == $past(link_v[4:0]) ##1 running && seg_ff == 4'h1)
      else $error("Linked program not started");
   chk_seg_adv: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ok_ctx && seg_end && seg_ff != `RSPS_LAST_SEG
      |=> seg_ff == 4'($past(seg_ff) + 4'h1) && tleft_ff == $past(dur_nxt))
      else $error("Segment did not advance on expiry");

endmodule // rsps_seq

`default_nettype wire

// [verification/tb_top.sv]
/*
 Self-checking bench for the ramp-and-soak program sequencer.
 Assumes rsps_seq with a 10-cycle base tick and a classic Wishbone slave.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rsps_defs.svh"
module tb_top;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic [3:0] sel = 4'h0;
   logic [15:0] i_pv = 16'h0000;
   logic [31:0] o_wb_dat;
   logic o_wb_ack;
   logic [15:0] o_setpoint;
   logic [3:0] o_event_alarm;
   logic o_ctrl_active;
   logic o_irq;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0001_4E7C;
   logic [31:0] sp, evfn, m_exp, m_msk;
   logic [31:0] win [0:28];
   logic [31:0] w2 [0:28];
   logic [31:0] exp_q [$];
   logic [31:0] msk_q [$];
   string nm_q [$];
   string m_nm;

   rsps_seq #(.P_SEC_CYC(32'h0000_000A)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pv(i_pv), .o_setpoint(o_setpoint),
      .o_event_alarm(o_event_alarm), .o_ctrl_active(o_ctrl_active), .o_irq(o_irq));

   initial begin
      forever #5 i_clk = ~i_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] fa(input int f);
      return 8'h80 | {1'b0, 5'(f), 2'b00};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 100);
      if (n >= 100) n_mismatch++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      nm_q.push_back($sformatf("reg_%h", a));
      bus(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (o_irq !== 1'b1 && n < 1000) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 1000) n_mismatch++;
   endtask

   task automatic setprog(input logic [4:0] p, input logic [31:0] d1, input logic [31:0] lk);
      wr(`RSPS_OFS_CTRL, {19'h0, p, 8'h40});
      for (int f = 0; f < 29; f++) begin
         seed = lfsr(seed);
         win[f] = (f < 10) ? sp : (f == 10) ? d1 : (f < 19) ? 32'h0000_0001 :
            (f < 28) ? {28'h0, seed[3:0]} : lk;
         wr(fa(f), win[f]);
      end
   endtask

   // Read results are compared against the oldest note
   always @(posedge i_clk) begin
      if (o_wb_ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         m_exp = exp_q.pop_front();
         m_msk = msk_q.pop_front();
         m_nm = nm_q.pop_front();
         check(m_nm, o_wb_dat & m_msk, m_exp);
      end
   end

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd(`RSPS_OFS_CTRL, 32'h0000_0140, ALL);
      check("ctrl_active", {31'h0, o_ctrl_active}, 32'h0000_0001);
      wr(8'h08, 32'h1234_5678);
      rd(8'h08, 32'h0000_0000, ALL);
      seed = lfsr(seed);
      sp = {20'h0, seed[11:0]};
      evfn = {28'h0, seed[15:12]};
      i_pv <= sp[15:0];
      wr(`RSPS_OFS_EVFN, evfn);
      rd(`RSPS_OFS_EVFN, evfn, ALL);
      $display("test reset and bus done");
      setprog(5'h02, 32'h0000_0005, 32'h0000_0003);
      w2 = win;
      setprog(5'h03, 32'h0000_0001, 32'h0000_0000);
      wr(`RSPS_OFS_CTRL, 32'h0000_0200);
      for (int f = 0; f < 29; f++) rd(fa(f), w2[f], ALL);
      $display("test program storage done");
      wr(`RSPS_OFS_IMSK, 32'h0000_0000);
      wr(`RSPS_OFS_TOL, 32'h0000_0000);
      wr(`RSPS_OFS_CTRL, 32'h0000_0202);
      repeat (50) @(posedge i_clk);
      check("ctrl_off", {31'h0, o_ctrl_active}, 32'h0000_0000);
      check("alarm_off", {28'h0, o_event_alarm}, 32'h0000_0000);
      rd(`RSPS_OFS_TLEFT, 32'h0000_0005, ALL);
      rd(`RSPS_OFS_STAT, 32'h0000_0221, 32'h0000_07FF);
      wr(`RSPS_OFS_CTRL, 32'h0000_0242);
      repeat (3) @(posedge i_clk);
      check("event", {28'h0, o_event_alarm}, w2[19] & evfn);
      check("setpoint", {16'h0, o_setpoint}, sp);
      rd(`RSPS_OFS_WSP, sp, ALL);
      i_pv <= sp[15:0] + 16'h2000;
      rd(`RSPS_OFS_STAT, 32'h0000_0221, 32'h0000_07FF);
      wr(`RSPS_OFS_IMSK, 32'h0000_0004);
      wr(`RSPS_OFS_TOL, 32'h0000_0001);
      repeat (3) @(posedge i_clk);
      rd(`RSPS_OFS_STAT, 32'h0000_0621, 32'h0000_07FF);
      check("irq_hold", {31'h0, o_irq}, 32'h0000_0001);
      wr(`RSPS_OFS_IST, 32'h0000_0004);
      check("irq_clear", {31'h0, o_irq}, 32'h0000_0000);
      repeat (60) @(posedge i_clk);
      rd(`RSPS_OFS_STAT, 32'h0000_0621, 32'h0000_07FF);
      $display("test enable and hold done");
      i_pv <= sp[15:0];
      wr(`RSPS_OFS_IST, 32'h0000_0007);
      wr(`RSPS_OFS_IMSK, 32'h0000_0002);
      wait_irq();
      check("irq_end", {31'h0, o_irq}, 32'h0000_0001);
      rd(`RSPS_OFS_STAT, 32'h0000_0231, 32'h0000_07FF);
      wr(`RSPS_OFS_IST, 32'h0000_0007);
      check("irq_clr2", {31'h0, o_irq}, 32'h0000_0000);
      wait_irq();
      rd(`RSPS_OFS_STAT, 32'h0000_0000, 32'h0000_0200);
      $display("test link done");
      wr(`RSPS_OFS_CTRL, 32'h0000_0260);
      wr(`RSPS_OFS_CTRL, 32'h0000_0263);
      repeat (300) @(posedge i_clk);
      rd(`RSPS_OFS_TLEFT, 32'h0000_0001, ALL);
      rd(`RSPS_OFS_STAT, 32'h0000_0231, 32'h0000_07FF);
      wr(`RSPS_OFS_CTRL, 32'h0000_0260);
      rd(`RSPS_OFS_STAT, 32'h0000_0000, 32'h0000_0200);
      $display("test time base done");
      conclude();
   end
endmodule // tb_top
`default_nettype wire
